// >>> cvc_cfg.svh
// Constants for the second converter control register.
`ifndef CVC_CFG_SVH
`define CVC_CFG_SVH
`define CVC_REG_OFFSET 8'h02
`define CVC_RESET_VALUE 8'hC1
`define CVC_DGL_MSB 7
`define CVC_DGL_LSB 6
`define CVC_FREQ_MSB 5
`define CVC_FREQ_LSB 4
`define CVC_SSTOP_BIT 3
`define CVC_ILIM_MSB 2
`define CVC_ILIM_LSB 0
`define CVC_CLK_MHZ 250
// Deglitch delays in ns; the shortest level is one clock.
`define CVC_DGL0_NS 4
`define CVC_DGL1_NS 6000
`define CVC_DGL2_NS 12000
`define CVC_DGL3_NS 30000
// Switching periods in ns for 500 kHz, 750 kHz, 1 MHz, 1.25 MHz.
`define CVC_PER0_NS 2000
`define CVC_PER1_NS 1333
`define CVC_PER2_NS 1000
`define CVC_PER3_NS 800
// Soft-stop ramp step time in ns per output code.
`define CVC_SSTEP_NS 40
`define CVC_CYC(ns) (((ns) * `CVC_CLK_MHZ) / 1000)
`endif

// >>> cvc_control_two.sv
// Second converter control register with the logic its fields steer.
//
// Contract
// - Bits 7:6 pick power-good deglitch delay.
// - Power-good changes only after deglitch delay.
// - Host may write any of four delays.
// - Bits 5:4 pick switching frequency.
// - Frequency set by on-time timer, no oscillator.
// - Soft stop zero leaves output undriven.
// - Soft stop one ramps output linearly down.
// - Bits 2:0 pick valley current limit.
// - Enable pin low stops converter and port.
`timescale 1ns/1ps
`include "cvc_cfg.svh"
module cvc_control_two (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic converterOnInput,
  input wire logic softEnable,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] outputTarget,
  input wire logic overvoltageTrip,
  input wire logic undervoltageTrip,
  output cvc_pkg::cvc_byte_t regRdata,
  output logic regRvalid,
  output logic powerGoodOutput,
  output logic onTimePulse,
  output logic converterActive,
  output logic outputDriven,
  output logic [7:0] outputVoltage,
  output logic [2:0] valleyLimitSel
);
  import cvc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  cvc_byte_t ctrl_q;
  cvc_state_t state_q;
  cvc_count_t period_q;
  cvc_count_t periodLimit;
  cvc_count_t step_q;
  logic portOn;
  logic pgRaw;
  cvc_count_t pgRun_q;
  cvc_count_t pgDelay;
  assign portOn = converterOnInput;
  // Register write and read-back; the port is dead while the enable pin is low.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `CVC_RESET_VALUE;
    end else if (clkEn && portOn && regWrite && regAddr == `CVC_REG_OFFSET) begin
      ctrl_q <= regWdata;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 8'h00;
      regRvalid <= 1'b0;
    end else if (clkEn) begin
      regRvalid <= portOn && regRead && regAddr == `CVC_REG_OFFSET;
      if (portOn && regRead && regAddr == `CVC_REG_OFFSET) begin
        regRdata <= ctrl_q;
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valleyLimitSel <= 3'h0;
    end else if (clkEn) begin
      valleyLimitSel <= ctrl_q[`CVC_ILIM_MSB:`CVC_ILIM_LSB];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Converter state: off, running, or ramping down after shutdown.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CVC_ST_OFF;
    end else if (clkEn) begin
      unique case (state_q)
        CVC_ST_OFF: begin
          if (portOn && softEnable) state_q <= CVC_ST_RUN;
        end
        CVC_ST_RUN: begin
          if (!(portOn && softEnable)) begin
            state_q <= ctrl_q[`CVC_SSTOP_BIT] ? CVC_ST_STOP : CVC_ST_OFF;
          end
        end
        CVC_ST_STOP: begin
          if (outputVoltage == 8'h00) state_q <= CVC_ST_OFF;
          else if (portOn && softEnable) state_q <= CVC_ST_RUN;
        end
        default: state_q <= CVC_ST_OFF;
      endcase
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      converterActive <= 1'b0;
      outputDriven <= 1'b0;
    end else if (clkEn) begin
      converterActive <= state_q == CVC_ST_RUN;
      outputDriven <= state_q != CVC_ST_OFF;
    end
  end
  // Linear ramp: one code down per step time while stopping.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_q <= 14'h0000;
      outputVoltage <= 8'h00;
    end else if (clkEn) begin
      if (state_q == CVC_ST_RUN) begin
        outputVoltage <= outputTarget;
        step_q <= 14'h0000;
      end else if (state_q == CVC_ST_STOP && outputVoltage != 8'h00) begin
        if (step_q + 14'h0001 >= 14'(`CVC_CYC(`CVC_SSTEP_NS))) begin
          step_q <= 14'h0000;
          outputVoltage <= outputVoltage - 8'h01;
        end else begin
          step_q <= step_q + 14'h0001;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // No free-running oscillator: the on-time timer length fixes the period.
  // The host must keep the chosen period above the minimum on-time.
  always_comb begin
    unique case (ctrl_q[`CVC_FREQ_MSB:`CVC_FREQ_LSB])
      2'b00: periodLimit = 14'(`CVC_CYC(`CVC_PER0_NS));
      2'b01: periodLimit = 14'(`CVC_CYC(`CVC_PER1_NS));
      2'b10: periodLimit = 14'(`CVC_CYC(`CVC_PER2_NS));
      2'b11: periodLimit = 14'(`CVC_CYC(`CVC_PER3_NS));
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      period_q <= 14'h0000;
      onTimePulse <= 1'b0;
    end else if (clkEn) begin
      if (state_q != CVC_ST_RUN || period_q + 14'h0001 >= periodLimit) begin
        period_q <= 14'h0000;
      end else begin
        period_q <= period_q + 14'h0001;
      end
      onTimePulse <= state_q == CVC_ST_RUN && period_q == 14'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  assign pgRaw = !overvoltageTrip && !undervoltageTrip;
  cvc_pg_deglitch uDeglitch (
    .clk(clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .delaySel(ctrl_q[`CVC_DGL_MSB:`CVC_DGL_LSB]),
    .inWindow(pgRaw),
    .pgOut(powerGoodOutput)
  );
  // Expected deglitch length per delay code, kept apart from the filter so the check does not trust it.
  always_comb begin
    unique case (ctrl_q[`CVC_DGL_MSB:`CVC_DGL_LSB])
      2'b00: pgDelay = 14'(`CVC_CYC(`CVC_DGL0_NS));
      2'b01: pgDelay = 14'(`CVC_CYC(`CVC_DGL1_NS));
      2'b10: pgDelay = 14'(`CVC_CYC(`CVC_DGL2_NS));
      2'b11: pgDelay = 14'(`CVC_CYC(`CVC_DGL3_NS));
    endcase
  end
  // Assertion helper: enabled cycles in a row in which the raw comparator disagrees with the output.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pgRun_q <= 14'h0000;
    end else if (clkEn) begin
      if (pgRaw == powerGoodOutput || pgRun_q + 14'h0001 >= pgDelay) begin
        pgRun_q <= 14'h0000;
      end else begin
        pgRun_q <= pgRun_q + 14'h0001;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_reg_readback: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && portOn && regRead && regAddr == `CVC_REG_OFFSET |=> regRvalid && regRdata == $past(ctrl_q))
    else $error("Read-back differs from register.");
  a_write_takes: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && portOn && regWrite && regAddr == `CVC_REG_OFFSET |=> ctrl_q == $past(regWdata))
    else $error("Write not stored.");
  a_pin_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && !portOn |=> $stable(ctrl_q) && !regRvalid)
    else $error("Port active with enable pin low.");
  a_off_pin: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && !portOn && state_q == CVC_ST_RUN |=> state_q != CVC_ST_RUN)
    else $error("Converter stays on with pin low.");
  // A shutdown request while running, split by the soft-stop bit.
  sequence s_stopPlain;
    clkEn && state_q == CVC_ST_RUN && !(portOn && softEnable) && !ctrl_q[`CVC_SSTOP_BIT];
  endsequence
  sequence s_stopSoft;
    clkEn && state_q == CVC_ST_RUN && !(portOn && softEnable) && ctrl_q[`CVC_SSTOP_BIT];
  endsequence
  a_no_sstop: assert property (@(posedge clk) disable iff (!reset_n)
    s_stopPlain |=> state_q == CVC_ST_OFF)
    else $error("Discharge without soft stop.");
  a_sstop_enter: assert property (@(posedge clk) disable iff (!reset_n)
    s_stopSoft |=> state_q == CVC_ST_STOP)
    else $error("Soft stop not entered.");
  a_ramp_down: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == CVC_ST_STOP && $past(state_q) == CVC_ST_STOP |-> outputVoltage <= $past(outputVoltage))
    else $error("Soft-stop ramp rises.");
  a_ramp_rate: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && state_q == CVC_ST_STOP
    |=> outputVoltage == $past(outputVoltage) || outputVoltage == $past(outputVoltage) - 8'h01)
    else $error("Soft-stop ramp steps too far.");
  a_pg_stable: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && pgRaw != powerGoodOutput && pgRun_q + 14'h0001 < pgDelay |=> $stable(powerGoodOutput))
    else $error("Power good moved before delay.");
  a_pg_follow: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && pgRaw != powerGoodOutput && pgRun_q + 14'h0001 >= pgDelay |=> powerGoodOutput == $past(pgRaw))
    else $error("Power good missed its delay.");
  a_ton_period: assert property (@(posedge clk) disable iff (!reset_n)
    onTimePulse && clkEn |=> !onTimePulse)
    else $error("On-time pulses back to back.");
  a_ton_run: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(onTimePulse) |-> $past(state_q) == CVC_ST_RUN)
    else $error("On-time pulse while not running.");
  a_ilim_map: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn |=> valleyLimitSel == $past(ctrl_q[`CVC_ILIM_MSB:`CVC_ILIM_LSB]))
    else $error("Current limit select wrong.");
  a_en_freeze: assert property (@(posedge clk) disable iff (!reset_n)
    !clkEn |=> $stable(ctrl_q) && $stable(state_q) && $stable(outputVoltage) && $stable(regRvalid))
    else $error("State moved while clock enable low.");
endmodule : cvc_control_two

// >>> cvc_host_model.sv
// Parallel-bus host model driving register accesses.
`timescale 1ns/1ps
module cvc_host_model (
  input wire logic clk,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic regRvalid,
  input wire cvc_pkg::cvc_byte_t regRdata
);
  import cvc_pkg::*;
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // Released lines show the inverse so a stale value never looks valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output cvc_byte_t d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    regAddr = ~a;
    repeat (3) begin
      if (!ok && regRvalid === 1'b1) begin
        ok = 1'b1;
        d = regRdata;
      end
      if (!ok) @(negedge clk);
    end
  endtask : rd
endmodule : cvc_host_model

// >>> cvc_pg_deglitch.sv
// Power-good deglitch filter with a selectable delay.
`timescale 1ns/1ps
`include "cvc_cfg.svh"
module cvc_pg_deglitch (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [1:0] delaySel,
  input wire logic inWindow,
  output logic pgOut
);
  import cvc_pkg::*;
  cvc_count_t limit;
  cvc_count_t cnt_q;
  always_comb begin
    unique case (delaySel)
      2'b00: limit = 14'(`CVC_CYC(`CVC_DGL0_NS));
      2'b01: limit = 14'(`CVC_CYC(`CVC_DGL1_NS));
      2'b10: limit = 14'(`CVC_CYC(`CVC_DGL2_NS));
      2'b11: limit = 14'(`CVC_CYC(`CVC_DGL3_NS));
    endcase
  end
  // The count restarts whenever the comparator agrees with the output, so a glitch shorter than the delay is lost.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 14'h0000;
      pgOut <= 1'b0;
    end else if (clkEn) begin
      if (inWindow == pgOut) begin
        cnt_q <= 14'h0000;
      end else if (cnt_q + 14'h0001 >= limit) begin
        pgOut <= inWindow;
        cnt_q <= 14'h0000;
      end else begin
        cnt_q <= cnt_q + 14'h0001;
      end
    end
  end
endmodule : cvc_pg_deglitch

// >>> cvc_pkg.sv
// Types for the second converter control register.
package cvc_pkg;
  typedef enum logic [1:0] {
    CVC_ST_OFF = 2'b00,
    CVC_ST_RUN = 2'b01,
    CVC_ST_STOP = 2'b10
  } cvc_state_t;
  typedef logic [7:0] cvc_byte_t;
  typedef logic [13:0] cvc_count_t;
endpackage : cvc_pkg

// >>> test_cvc_control_two.sv
// Directed bench for the second converter control register.
`timescale 1ns/1ps
module test_cvc_control_two;
  import cvc_pkg::*;
  logic clk = 0, reset_n = 0, onPin = 0, softEn = 0, ov = 0, uv = 0, en = 1;
  logic wrS, rdS, rv, pg, pulse, act, drv;
  logic [7:0] addr, wd, output_voltage;
  logic [2:0] limSel;
  cvc_byte_t rdat;
  logic [3:0] obs;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;
  int per[4] = '{500, 333, 250, 200};
  int dgl[4] = '{1, 1500, 3000, 7500};
  assign obs = {act, drv, pulse, pg};
  always #2 clk = ~clk;
  cvc_control_two cvc_control_two_i (.clk(clk), .reset_n(reset_n), .clkEn(en),
    .converterOnInput(onPin), .softEnable(softEn), .regWrite(wrS), .regRead(rdS),
    .regAddr(addr), .regWdata(wd), .outputTarget(8'h20), .overvoltageTrip(ov),
    .undervoltageTrip(uv), .regRdata(rdat), .regRvalid(rv), .powerGoodOutput(pg),
    .onTimePulse(pulse), .converterActive(act), .outputDriven(drv),
    .outputVoltage(output_voltage), .valleyLimitSel(limSel));
  cvc_host_model cvc_host_model_i (.clk(clk), .regWrite(wrS), .regRead(rdS),
    .regAddr(addr), .regWdata(wd), .regRvalid(rv), .regRdata(rdat));
  //////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // Counts falling edges until an observed bit reaches v; a hang ends the run.
  task automatic waitCnt(input int b, input logic v, input int lim, output int c);
    c = 0;
    while (obs[b] !== v) begin
      @(negedge clk);
      c++;
      if (c > lim) begin
        error_cnt++;
        close_out();
      end
    end
  endtask : waitCnt
  task automatic rdChk(string nm, logic [7:0] a, logic [7:0] exp, logic expOk);
    cvc_byte_t d;
    logic ok;
    cvc_host_model_i.rd(a, d, ok);
    chk(nm, {7'h00, ok, ok ? d : 8'h00}, {7'h00, expOk, expOk ? exp : 8'h00});
  endtask : rdChk
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1;
    onPin = 1;
    @(negedge clk);
    chk("limSel", 16'(limSel), 16'h0001);
    rdChk("resetVal", 8'h02, 8'hC1, 1);
    for (int i = 0; i < 8; i++) begin
      cvc_host_model_i.wr(8'h02, 8'(8'h58 + i));
      @(negedge clk);
      chk("limSel", 16'(limSel), 16'(i));
    end
    rdChk("readBack", 8'h02, 8'h5F, 1);
    cvc_host_model_i.wr(8'h03, 8'h00);
    rdChk("badAddr", 8'h03, 8'h00, 0);
    onPin = 0;
    cvc_host_model_i.wr(8'h02, 8'h00);
    onPin = 1;
    rdChk("pinLowWr", 8'h02, 8'h5F, 1);
    // Let the read answer drop before freezing, or the frozen valid would look like a new answer.
    @(negedge clk);
    en = 0;
    cvc_host_model_i.wr(8'h02, 8'h00);
    rdChk("frozenRd", 8'h02, 8'h00, 0);
    en = 1;
    rdChk("frozenWr", 8'h02, 8'h5F, 1);
    softEn = 1;
    // Only frequencies whose on-time stays above the minimum are chosen.
    for (int f = 0; f < 4; f++) begin
      cvc_host_model_i.wr(8'h02, {2'b00, 2'(f), 4'h1});
      waitCnt(1, 1, 600, n);
      @(negedge clk);
      waitCnt(1, 1, 600, n);
      chk("period", 16'(n + 1), 16'(per[f]));
    end
    waitCnt(0, 1, 10, n);
    for (int d = 0; d < 4; d++) begin
      cvc_host_model_i.wr(8'h02, {2'(d), 6'h01});
      if (d == 3) begin
        ov = 1;
        repeat (10) @(negedge clk);
        ov = 0;
        repeat (3) @(negedge clk);
        chk("glitch", 16'(pg), 16'h0001);
      end
      if (d[0]) uv = 1;
      else ov = 1;
      waitCnt(0, 0, 8000, n);
      chk("pgFall", 16'(n >= dgl[d] && n <= dgl[d] + 2), 16'h0001);
      ov = 0;
      uv = 0;
      waitCnt(0, 1, 8000, n);
      chk("pgRise", 16'(n >= dgl[d] && n <= dgl[d] + 2), 16'h0001);
    end
    softEn = 0;
    waitCnt(2, 0, 4, n);
    chk("noDrive", 16'(drv), 16'h0000);
    cvc_host_model_i.wr(8'h02, 8'h09);
    softEn = 1;
    waitCnt(3, 1, 4, n);
    repeat (4) @(negedge clk);
    chk("output_voltage", 16'(output_voltage), 16'h0020);
    softEn = 0;
    repeat (165) @(negedge clk);
    chk("rampMid", 16'(output_voltage >= 8'h0F && output_voltage <= 8'h11 && drv), 16'h0001);
    waitCnt(2, 0, 200, n);
    chk("rampEnd", 16'(output_voltage), 16'h0000);
    softEn = 1;
    waitCnt(3, 1, 4, n);
    onPin = 0;
    waitCnt(3, 0, 4, n);
    rdChk("pinLowRd", 8'h02, 8'h00, 0);
    close_out();
  end
endmodule : test_cvc_control_two
